/* inc/asp_map.vh */
`ifndef ASP_MAP_VH
`define ASP_MAP_VH
// bus shape
`define ASP_ADDR_W 15
`define ASP_DATA_W 16
`define ASP_WORDS 32768
`define ASP_LO_MSB 7
`define ASP_HI_LSB 8
// pin reset levels (all inactive high)
`define ASP_CTL_IDLE 1'b1
// timing in ns, slowest grade
`define ASP_T_ADDR_SETUP_NS 0
`define ASP_T_WE_PULSE_NS 12
`define ASP_T_DATA_SETUP_NS 10
`define ASP_T_ACCESS_NS 20
`define ASP_T_HIZ_NS 9
`define ASP_CLK_PERIOD_NS 50
// cycles: least times round up, never below one
`define ASP_CYC_UP(ns) (((ns) + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_CYC_MIN1(ns) ((`ASP_CYC_UP(ns) < 1) ? 1 : `ASP_CYC_UP(ns))
`define ASP_WR_CYC `ASP_CYC_MIN1(`ASP_T_WE_PULSE_NS)
`define ASP_RD_CYC `ASP_CYC_MIN1(`ASP_T_ACCESS_NS)
`define ASP_TURN_CYC `ASP_CYC_MIN1(`ASP_T_HIZ_NS)
`endif

/* rtl/asp_wait_cnt.v */
`include "asp_map.vh"
`default_nettype none
module asp_wait_cnt (
    // clock and reset
    input wire clk,
    input wire nrst,
    // control
    input wire load,
    input wire [3:0] count,
    // status
    output wire done
);
reg [3:0] cnt_q;
always @(posedge clk) begin
    if (!nrst) begin
        cnt_q <= 4'h0;
    end else if (load) begin
        cnt_q <= count;
    end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
    end
end
assign done = (cnt_q == 4'h0) && !load;
endmodule
`default_nettype wire

/* rtl/asp_host.v */
// Notes on behaviour
// - write only while select and strobe low
// - read: select, output enable low, strobe high
// - host times data to terminating edge
// - address valid by select falling edge
`include "asp_map.vh"
`default_nettype none
module asp_host (
    // clock and reset
    input wire clk,
    input wire nrst,
    // user request
    input wire req_valid,
    output wire req_ready,
    input wire req_write,
    input wire [`ASP_ADDR_W-1:0] req_addr,
    input wire [`ASP_DATA_W-1:0] req_wdata,
    input wire [1:0] req_lane_n,
    // user answer
    output reg rsp_valid,
    output reg [`ASP_DATA_W-1:0] rsp_rdata,
    // memory pins
    output reg [`ASP_ADDR_W-1:0] mem_addr,
    output reg chip_select_n,
    output reg write_strobe_n,
    output reg output_enable_n,
    output reg lower_lane_enable_n,
    output reg upper_lane_enable_n,
    input wire [`ASP_DATA_W-1:0] mem_data_in,
    output reg [`ASP_DATA_W-1:0] mem_data_out,
    output reg mem_data_oe
);
////////////////////////////////////////////////////////////////////////
// cycle count held in four bits, longer waits saturate
function [3:0] cyc4;
    input integer cyc;
    begin
        cyc4 = (cyc > 15) ? 4'hf : cyc[3:0];
    end
endfunction

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_WSET = 3'h1;
localparam [2:0] ST_WPULSE = 3'h2;
localparam [2:0] ST_WEND = 3'h3;
localparam [2:0] ST_RSET = 3'h4;
localparam [2:0] ST_RWAIT = 3'h5;
localparam [2:0] ST_TURN = 3'h6;
localparam [2:0] ST_REND = 3'h7;
localparam [3:0] WR_CYC = cyc4(`ASP_WR_CYC);
localparam [3:0] RD_CYC = cyc4(`ASP_RD_CYC);
localparam [3:0] TURN_CYC = cyc4(`ASP_TURN_CYC);

reg [2:0] state_q;
reg [3:0] cnt_ld;
reg cnt_load;
wire cnt_done;

// any lane selected, else the request has no effect on the word
function lane_any;
    input [1:0] ln;
    begin
        lane_any = ~(ln[0] & ln[1]);
    end
endfunction

// byte of a read lane, zero where the lane is off
function [7:0] lane_pick;
    input en_n;
    input [7:0] d;
    begin
        lane_pick = en_n ? 8'h00 : d;
    end
endfunction

////////////////////////////////////////////////////////////////////////
asp_wait_cnt u_wait (
    .clk(clk),
    .nrst(nrst),
    .load(cnt_load),
    .count(cnt_ld),
    .done(cnt_done)
);

assign req_ready = (state_q == ST_IDLE);

always @* begin
    cnt_load = 1'b0;
    cnt_ld = 4'h0;
    case (state_q)
        ST_WSET: begin
            cnt_load = 1'b1;
            cnt_ld = WR_CYC;
        end
        ST_RSET: begin
            cnt_load = 1'b1;
            cnt_ld = RD_CYC;
        end
        ST_WEND: begin
            cnt_load = 1'b1;
            cnt_ld = TURN_CYC;
        end
        ST_REND: begin
            cnt_load = 1'b1;
            cnt_ld = TURN_CYC;
        end
        default: begin
            cnt_load = 1'b0;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////
always @(posedge clk) begin
    if (!nrst) begin
        state_q <= ST_IDLE;
        mem_addr <= {`ASP_ADDR_W{1'b0}};
        chip_select_n <= `ASP_CTL_IDLE;
        write_strobe_n <= `ASP_CTL_IDLE;
        output_enable_n <= `ASP_CTL_IDLE;
        lower_lane_enable_n <= `ASP_CTL_IDLE;
        upper_lane_enable_n <= `ASP_CTL_IDLE;
        mem_data_out <= {`ASP_DATA_W{1'b0}};
        mem_data_oe <= 1'b0;
        rsp_valid <= 1'b0;
        rsp_rdata <= {`ASP_DATA_W{1'b0}};
    end else begin
        rsp_valid <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (req_valid && lane_any(req_lane_n)) begin
                    // address set before select falls
                    mem_addr <= req_addr;
                    lower_lane_enable_n <= req_lane_n[0];
                    upper_lane_enable_n <= req_lane_n[1];
                    if (req_write) begin
                        // output enable stays high on writes
                        output_enable_n <= 1'b1;
                        mem_data_out <= req_wdata;
                        state_q <= ST_WSET;
                    end else begin
                        state_q <= ST_RSET;
                    end
                end else if (req_valid) begin
                    rsp_valid <= 1'b1;
                end
            end
            ST_WSET: begin
                chip_select_n <= 1'b0;
                write_strobe_n <= 1'b0;
                mem_data_oe <= 1'b1;
                state_q <= ST_WPULSE;
            end
            ST_WPULSE: begin
                if (cnt_done) begin
                    // strobe alone ends the write, data held past it
                    write_strobe_n <= 1'b1;
                    state_q <= ST_WEND;
                end
            end
            ST_WEND: begin
                chip_select_n <= 1'b1;
                lower_lane_enable_n <= 1'b1;
                upper_lane_enable_n <= 1'b1;
                mem_data_oe <= 1'b0;
                rsp_valid <= 1'b1;
                state_q <= ST_TURN;
            end
            ST_RSET: begin
                chip_select_n <= 1'b0;
                output_enable_n <= 1'b0;
                state_q <= ST_RWAIT;
            end
            ST_RWAIT: begin
                if (cnt_done) begin
                    // disabled lane reads back as zero
                    rsp_rdata[`ASP_LO_MSB:0] <= lane_pick(
                        lower_lane_enable_n,
                        mem_data_in[`ASP_LO_MSB:0]);
                    rsp_rdata[`ASP_DATA_W-1:`ASP_HI_LSB] <= lane_pick(
                        upper_lane_enable_n,
                        mem_data_in[`ASP_DATA_W-1:`ASP_HI_LSB]);
                    rsp_valid <= 1'b1;
                    chip_select_n <= 1'b1;
                    output_enable_n <= 1'b1;
                    lower_lane_enable_n <= 1'b1;
                    upper_lane_enable_n <= 1'b1;
                    state_q <= ST_REND;
                end
            end
            ST_REND: begin
                // memory release after a read is counted as well
                state_q <= ST_TURN;
            end
            ST_TURN: begin
                if (cnt_done) begin
                    state_q <= ST_IDLE;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
    end
end
endmodule
`default_nettype wire

/* dv/asp_host_chk.sv */
`include "asp_map.vh"
`default_nettype none
module asp_host_chk (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // memory pins
    input wire logic [`ASP_ADDR_W-1:0] mem_addr,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic mem_data_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_cs_rise;
        ##1 $rose(chip_select_n);
    endsequence
    chk_wr_gate: assert property (!write_strobe_n |->
        !chip_select_n && mem_data_oe && output_enable_n) else $error("wr");
    chk_rd_gate: assert property (!output_enable_n |->
        write_strobe_n && !chip_select_n && !mem_data_oe) else $error("rd");
    chk_idle_float: assert property (chip_select_n |->
        !mem_data_oe) else $error("float");
    chk_wr_end: assert property ($rose(write_strobe_n) |->
        s_cs_rise) else $error("end");
    chk_no_joint: assert property ($rose(chip_select_n) |->
        $past(write_strobe_n)) else $error("joint");
    chk_addr_held: assert property (!chip_select_n |->
        $stable(mem_addr)) else $error("addr");
    chk_we_pulse: assert property ($fell(write_strobe_n) |->
        ##2 $rose(write_strobe_n)) else $error("we pulse");
    chk_oe_window: assert property ($fell(output_enable_n) |->
        ##2 $rose(output_enable_n)) else $error("oe window");
endmodule
`default_nettype wire

/* dv/asp_mem_model.sv */
`include "asp_map.vh"
`default_nettype none
module asp_mem_model (
    // pins from host
    input wire logic [`ASP_ADDR_W-1:0] mem_addr,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic lower_lane_enable_n,
    input wire logic upper_lane_enable_n,
    input wire logic [`ASP_DATA_W-1:0] mem_data_out,
    input wire logic mem_data_oe,
    // bus level seen by host
    output logic [`ASP_DATA_W-1:0] mem_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [`ASP_WORDS];
    wire logic [15:0] w = mem_data_oe ? mem_data_out : ~mem_data_out;
    wire logic rd = !chip_select_n && !output_enable_n
        && write_strobe_n;
    always @*
        if (!chip_select_n && !write_strobe_n) begin
            if (!lower_lane_enable_n)
                mem[mem_addr][7:0] = w[7:0];
            if (!upper_lane_enable_n)
                mem[mem_addr][15:8] = w[15:8];
        end
    assign mem_data_in[7:0] = rd && !lower_lane_enable_n
        ? mem[mem_addr][7:0] : w[7:0];
    assign mem_data_in[15:8] = rd && !upper_lane_enable_n
        ? mem[mem_addr][15:8] : w[15:8];
endmodule
`default_nettype wire

/* dv/tb_asp_host.sv */
`include "asp_map.vh"
`default_nettype none
module tb_asp_host;
    timeunit 1ns / 1ns;
    logic clk = 0, nrst = 0, req_valid = 0, req_write = 0;
    logic [1:0] req_lane_n = 2'h3;
    logic [14:0] req_addr = 0;
    logic [15:0] req_wdata = 0, sh [8];
    wire logic req_ready, rsp_valid, chip_select_n, write_strobe_n;
    wire logic output_enable_n, lower_lane_enable_n, upper_lane_enable_n;
    wire logic mem_data_oe;
    wire logic [14:0] mem_addr;
    wire logic [15:0] rsp_rdata, mem_data_in, mem_data_out;
    int miscompares = 0, tests_run = 0;
    wire logic [7:0] idle_pins = {chip_select_n, write_strobe_n,
        output_enable_n, lower_lane_enable_n, upper_lane_enable_n,
        mem_data_oe, rsp_valid, req_ready};
    asp_host DUT (
        .clk(clk),
        .nrst(nrst),
        .req_valid(req_valid),
        .req_ready(req_ready),
        .req_write(req_write),
        .req_addr(req_addr),
        .req_wdata(req_wdata),
        .req_lane_n(req_lane_n),
        .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata),
        .mem_addr(mem_addr),
        .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n),
        .lower_lane_enable_n(lower_lane_enable_n),
        .upper_lane_enable_n(upper_lane_enable_n),
        .mem_data_in(mem_data_in),
        .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe)
    );
    asp_mem_model u_mem (
        .mem_addr(mem_addr),
        .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n),
        .output_enable_n(output_enable_n),
        .lower_lane_enable_n(lower_lane_enable_n),
        .upper_lane_enable_n(upper_lane_enable_n),
        .mem_data_out(mem_data_out),
        .mem_data_oe(mem_data_oe),
        .mem_data_in(mem_data_in)
    );
    initial forever #25 clk = ~clk;
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
            $display("mismatch %0t %h %h", $time, seen, exp);
        miscompares += int'(seen !== exp);
    endtask
    task automatic report_and_stop;
        $display("tests %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [15:0] exp_read(logic [15:0] v,
        logic [1:0] ln);
        return {ln[1] ? 8'h00 : v[15:8], ln[0] ? 8'h00 : v[7:0]};
    endfunction
    function automatic logic [15:0] exp_merge(logic [15:0] v,
        logic [15:0] d, logic [1:0] ln);
        return {ln[1] ? v[15:8] : d[15:8], ln[0] ? v[7:0] : d[7:0]};
    endfunction
    task automatic acc(logic w, int i, logic [15:0] d, logic [1:0] ln);
        int n = 0;
        while (req_ready !== 1'b1 && n++ < 9)
            @(negedge clk);
        check(16'(req_ready), 16'h1);
        @(posedge clk);
        req_valid <= 1;
        req_write <= w;
        req_addr <= 15'(i) * 15'h1249;
        req_wdata <= d;
        req_lane_n <= ln;
        @(posedge clk);
        req_valid <= 0;
        @(negedge clk);
        check(16'(req_ready), 16'(&ln));
        while (rsp_valid !== 1'b1 && n++ < 20)
            @(negedge clk);
        check(16'(rsp_valid), 16'h1);
        if (!w && !(&ln))
            check(rsp_rdata, exp_read(sh[i], ln));
        if (w)
            sh[i] = exp_merge(sh[i], d, ln);
    endtask
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'hea26));
        repeat (2) @(posedge clk);
        nrst <= 1;
        @(negedge clk);
        check(16'(idle_pins), 16'hf9);
        foreach (sh[k]) acc(1, k, 16'($urandom), 2'h0);
        acc(1, 7, 16'hbeef, 2'h1);
        acc(0, 7, 16'h0, 2'h0);
        repeat (80)
            acc(1'($urandom), 3'($urandom), 16'($urandom), 2'($urandom));
        report_and_stop();
    end
endmodule
bind asp_host asp_host_chk u_chk (
    .clk(clk),
    .nrst(nrst),
    .mem_addr(mem_addr),
    .chip_select_n(chip_select_n),
    .write_strobe_n(write_strobe_n),
    .output_enable_n(output_enable_n),
    .mem_data_oe(mem_data_oe)
);
`default_nettype wire
